// *** rco_gen_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface rco_gen_if;
    logic src_level;
    logic src_edge;
    logic src_rise;
    logic src_valid;
    logic [3:0] src_sel;
    logic [2:0] div_sel;
    logic [1:0] duty_sel;
    logic start;
    logic hold;
    logic wave_next;

    modport pick (input src_sel, output src_level, output src_edge, output src_rise,
                  output src_valid);
    modport gen (input src_edge, input div_sel, input duty_sel, input start, input hold,
                 output wave_next);
    modport ctrl (input src_level, input src_edge, input src_rise, input src_valid,
                  input wave_next, output src_sel, output div_sel, output duty_sel,
                  output start, output hold);
endinterface : rco_gen_if
`default_nettype wire

// *** rco_pkg.sv ***
package rco_pkg;

    // ------------------------------------------------------------------
    // bus and register map
    // ------------------------------------------------------------------
    localparam int RCO_ADDR_W = 12;
    localparam int RCO_DATA_W = 32;
    localparam logic [RCO_ADDR_W-1:0] RCO_OFS_CONTROL = 12'h000;
    localparam logic [RCO_ADDR_W-1:0] RCO_OFS_SOURCE = 12'h004;
    localparam logic [RCO_ADDR_W-1:0] RCO_OFS_STATUS = 12'h008;

    // ------------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------------
    localparam int RCO_EN_POS = 7;
    localparam int RCO_DUTY_LSB = 3;
    localparam int RCO_DUTY_W = 2;
    localparam int RCO_DIV_LSB = 0;
    localparam int RCO_DIV_W = 3;
    localparam int RCO_SRC_W = 4;
    localparam int RCO_STAT_RUN_POS = 0;
    localparam int RCO_STAT_ARM_POS = 1;
    localparam int RCO_STAT_OUT_POS = 2;
    localparam logic [7:0] RCO_CTRL_RESET = 8'h10;
    localparam logic [7:0] RCO_CTRL_MASK = 8'h9f;
    localparam logic [7:0] RCO_SRC_RESET = 8'h00;
    localparam logic [7:0] RCO_SRC_MASK = 8'h0f;

    // ------------------------------------------------------------------
    // source codes and divider encodings
    // ------------------------------------------------------------------
    localparam int RCO_NUM_ASYNC = 9;
    localparam logic [3:0] RCO_SRC_FOSC = 4'h0;
    localparam logic [3:0] RCO_SRC_HFOSC = 4'h1;
    localparam logic [3:0] RCO_SRC_LFOSC = 4'h2;
    localparam logic [3:0] RCO_SRC_MF500K = 4'h3;
    localparam logic [3:0] RCO_SRC_MF31K = 4'h4;
    localparam logic [3:0] RCO_SRC_NCO = 4'h6;
    localparam logic [3:0] RCO_SRC_LC1 = 4'h7;
    localparam logic [3:0] RCO_SRC_LC2 = 4'h8;
    localparam logic [3:0] RCO_SRC_LC3 = 4'h9;
    localparam logic [3:0] RCO_SRC_LC4 = 4'ha;
    localparam logic [2:0] RCO_DIV_NONE = 3'h0;
    localparam int RCO_PHASE_W = 8;

    typedef enum logic [1:0] {
        RCO_OFF = 2'b00,
        RCO_ARM = 2'b01,
        RCO_RUN = 2'b10
    } rco_state_t;

    // high half-periods: duty quarters of 2^(div+1) halves
    function automatic logic [8:0] rco_high_len(input logic [2:0] div, input logic [1:0] duty);
        logic [8:0] scaled;
        scaled = 9'({7'h00, duty} << div);
        return scaled >> 1;
    endfunction : rco_high_len

    // last phase of a divided period, counted in source half-periods
    function automatic logic [RCO_PHASE_W-1:0] rco_period_last(input logic [2:0] div);
        logic [8:0] halves;
        halves = 9'(9'h002 << div);
        return 8'(halves - 9'h001);
    endfunction : rco_period_last

endpackage : rco_pkg

// *** rco_refclk_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module rco_refclk_monitor
    import rco_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_arst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [RCO_ADDR_W-1:0] i_paddr,
    input wire logic [RCO_DATA_W-1:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    input wire logic [RCO_DATA_W-1:0] o_prdata,
    input wire logic o_pready,
    input wire logic i_sleep,
    input wire logic o_refclk_out_pin
);
    // ------------
    // shadow of the registers
    // ------------
    logic wr, wr_c, wr_s, rd, rsv, ok_q, ok_d;
    logic [7:0] c_q, c_d, s_q, s_d;
    logic [3:0] age_q, age_d;
    logic [8:0] hi_q, hi_d;
    assign wr = i_psel && i_penable && i_pwrite && i_pstrb[0] && o_pready;
    assign rd = i_psel && i_penable && !i_pwrite;
    assign wr_c = wr && i_paddr == RCO_OFS_CONTROL;
    assign wr_s = wr && i_paddr == RCO_OFS_SOURCE;
    assign rsv = s_q[3:0] == 4'h5 || s_q[3:0] > RCO_SRC_LC4;
    always_comb
    begin
        c_d = wr_c ? i_pwdata[7:0] & RCO_CTRL_MASK : c_q;
        s_d = wr_s ? i_pwdata[7:0] & RCO_SRC_MASK : s_q;
        age_d = (wr_c || wr_s || !c_q[7]) ? 4'h0 : age_q + 4'(age_q != 4'hf);
        ok_d = wr_c ? 1'b1 : ok_q && !i_sleep;
        hi_d = (wr_c || !o_refclk_out_pin) ? 9'h000 : hi_q + 9'h001;
    end
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            c_q <= RCO_CTRL_RESET;
            s_q <= RCO_SRC_RESET;
            age_q <= 4'h0;
            ok_q <= 1'b0;
            hi_q <= 9'h000;
        end
        else
        begin
            c_q <= c_d;
            s_q <= s_d;
            age_q <= age_d;
            ok_q <= ok_d;
            hi_q <= hi_d;
        end
    end
    // ------------
    // properties
    // ------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_arst_n);
    property p_off;
        !c_q[7] [*2] |-> !o_refclk_out_pin;
    endproperty
    property p_stop;
        wr_c && !i_pwdata[7] && c_q[7] |=> ##1 !o_refclk_out_pin [*3];
    endproperty
    property p_follow;
        ok_q && c_q[7] && c_q[2:0] == RCO_DIV_NONE && s_q[3:0] == RCO_SRC_FOSC && age_q > 4'h8
            |-> o_refclk_out_pin != $past(o_refclk_out_pin);
    endproperty
    property p_zero;
        c_q[7] && c_q[4:3] == 2'b00 && c_q[2:0] != RCO_DIV_NONE && age_q > 4'h8
            |-> !o_refclk_out_pin;
    endproperty
    property p_high;
        ok_q && c_q[7] && s_q[3:0] == RCO_SRC_FOSC && c_q[2:0] != RCO_DIV_NONE
            && $fell(o_refclk_out_pin) |-> hi_q == 9'({7'h00, c_q[4:3]} << c_q[2:0]) >> 1;
    endproperty
    property p_sleep;
        i_sleep && c_q[7] |=> $stable(o_refclk_out_pin);
    endproperty
    property p_rsv;
        c_q[7] && rsv && age_q > 4'h3 |-> !o_refclk_out_pin;
    endproperty
    property p_rd_ctrl;
        rd && i_paddr == RCO_OFS_CONTROL |-> o_prdata == {24'h000000, c_q};
    endproperty
    property p_rd_src;
        rd && i_paddr == RCO_OFS_SOURCE |-> o_prdata == {24'h000000, s_q};
    endproperty
    a_off: assert property (p_off)
        else $error("pin active while disabled");
    a_stop: assert property (p_stop)
        else $error("pin not stopped");
    a_follow: assert property (p_follow)
        else $error("pin not following source");
    a_zero: assert property (p_zero)
        else $error("zero duty output not low");
    a_high: assert property (p_high)
        else $error("high time wrong");
    a_sleep: assert property (p_sleep)
        else $error("pin moved in sleep");
    a_rsv: assert property (p_rsv)
        else $error("reserved source drives pin");
    a_rd_ctrl: assert property (p_rd_ctrl)
        else $error("control read back wrong");
    a_rd_src: assert property (p_rd_src)
        else $error("source read back wrong");
    cover property (wr_c && i_pwdata[7]);
    cover property (i_sleep && c_q[7]);
    cover property (c_q[7] && rsv && age_q == 4'hf);
endmodule : rco_refclk_monitor
bind rco_refclk_top rco_refclk_monitor i_rco_refclk_monitor (.i_clock(i_clock),
    .i_arst_n(i_arst_n), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_prdata(o_prdata),
    .o_pready(o_pready), .i_sleep(i_sleep), .o_refclk_out_pin(o_refclk_out_pin));
`default_nettype wire

// *** rco_refclk_sink.sv ***
`timescale 1ns/1ps
`default_nettype none
// times high and low runs of the pin
module rco_refclk_sink
(
    input wire logic i_clock,
    input wire logic i_arst_n,
    input wire logic i_pin,
    output logic [8:0] o_high,
    output logic [8:0] o_low,
    output logic [15:0] o_rises
);
    logic [8:0] run_q, run_d, high_d, low_d;
    logic [15:0] rise_d;
    logic last_q;
    always_comb
    begin
        run_d = run_q + 9'h001;
        high_d = o_high;
        low_d = o_low;
        rise_d = o_rises;
        if (i_pin != last_q)
        begin
            run_d = 9'h001;
            if (last_q)
                high_d = run_q;
            else
            begin
                low_d = run_q;
                rise_d = o_rises + 16'h0001;
            end
        end
    end
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            run_q <= 9'h000;
            last_q <= 1'b0;
            o_high <= 9'h000;
            o_low <= 9'h000;
            o_rises <= 16'h0000;
        end
        else
        begin
            run_q <= run_d;
            last_q <= i_pin;
            o_high <= high_d;
            o_low <= low_d;
            o_rises <= rise_d;
        end
    end
endmodule : rco_refclk_sink
`default_nettype wire

// *** rco_refclk_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module rco_refclk_tb_top import rco_pkg::*;;
    logic i_clock = 1'b0;
    logic i_arst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sleep = 1'b0, slow = 1'b0, rerr;
    logic [RCO_ADDR_W-1:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic [3:0] pstrb = 4'hf;
    logic [2:0] tick = 3'h0;
    logic [8:0] mask = 9'h000, hi, lo;
    logic [15:0] rises;
    logic pready, pslverr, pin;
    wire logic [8:0] src;
    int err_total = 0, samples_checked = 0;
    assign src = mask & {9{slow}};
    always #10 i_clock = !i_clock;
    // 16-clock source
    always @(posedge i_clock)
    begin
        tick <= tick + 3'h1;
        if (tick == 3'h7)
            slow <= !slow;
    end
    rco_refclk_top i_rco_refclk_top (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_high_freq_internal_osc(src[0]), .i_low_freq_internal_osc(src[1]),
        .i_mid_freq_internal_osc_500k(src[2]), .i_mid_freq_internal_osc_31k(src[3]),
        .i_num_ctrl_osc_output(src[4]), .i_logic_cell1_output(src[5]),
        .i_logic_cell2_output(src[6]), .i_logic_cell3_output(src[7]),
        .i_logic_cell4_output(src[8]), .i_sleep(sleep), .o_refclk_out_pin(pin));
    rco_refclk_sink i_rco_refclk_sink (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_pin(pin),
        .o_high(hi), .o_low(lo), .o_rises(rises));
    // ------------
    // shared tasks
    // ------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [RCO_ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge i_clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clock);
        penable <= 1'b1;
        @(posedge i_clock);
        while (pready !== 1'b1)
            @(posedge i_clock);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd_chk(input logic [RCO_ADDR_W-1:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdat, exp);
        chk(32'(rerr), 32'h0);
    endtask : rd_chk
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clock);
    endtask : cyc
    task automatic wait_high();
        for (int i = 0; i < 600 && pin !== 1'b1; i++)
            @(posedge i_clock);
    endtask : wait_high
    // ------------
    // scenarios
    // ------------
    task automatic t_regs();
        rd_chk(RCO_OFS_CONTROL, 32'h10);
        rd_chk(RCO_OFS_SOURCE, 32'h0);
        apb(1'b1, RCO_OFS_CONTROL, 32'hff7f);
        rd_chk(RCO_OFS_CONTROL, 32'h1f);
        apb(1'b1, RCO_OFS_SOURCE, 32'hff);
        rd_chk(RCO_OFS_SOURCE, 32'h0f);
        pstrb <= 4'he;
        apb(1'b1, RCO_OFS_CONTROL, 32'h05);
        pstrb <= 4'hf;
        rd_chk(RCO_OFS_CONTROL, 32'h1f);
        apb(1'b1, RCO_OFS_SOURCE, 32'h0);
        apb(1'b0, 12'h00c, 32'h0);
        chk(32'(rerr), 32'h1);
        apb(1'b0, 12'h002, 32'h0);
        chk(32'(rerr), 32'h1);
        $display("test regs done");
    endtask : t_regs
    task automatic t_shape();
        logic [4:0] cfgs [12];
        logic [15:0] r0;
        logic [8:0] eh;
        cfgs = '{5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h17, 5'h0a, 5'h1a,
            5'h00, 5'h03};
        foreach (cfgs[k])
        begin
            apb(1'b1, RCO_OFS_CONTROL, 32'(cfgs[k]));
            apb(1'b1, RCO_OFS_CONTROL, 32'(cfgs[k]) | 32'h80);
            r0 = rises;
            cyc((6 << cfgs[k][2:0]) + 20);
            eh = cfgs[k][2:0] == 3'h0 ? 9'h001 : 9'({7'h00, cfgs[k][4:3]} << cfgs[k][2:0]) >> 1;
            if (eh == 9'h000)
                chk(32'(rises - r0), 32'h0);
            else
            begin
                chk(32'(hi), 32'(eh));
                chk(32'(lo), 32'(9'h002 << cfgs[k][2:0]) - 32'(eh));
            end
        end
        $display("test shape done");
    endtask : t_shape
    task automatic t_stop();
        apb(1'b1, RCO_OFS_CONTROL, 32'h1f);
        apb(1'b1, RCO_OFS_CONTROL, 32'h9f);
        wait_high();
        cyc(20);
        chk(32'(pin), 32'h1);
        rd_chk(RCO_OFS_STATUS, 32'h5);
        apb(1'b1, RCO_OFS_CONTROL, 32'h1f);
        @(posedge i_clock);
        #1;
        chk(32'(pin), 32'h0);
        $display("test stop done");
    endtask : t_stop
    task automatic t_sleep();
        logic lvl;
        logic [15:0] r0;
        apb(1'b1, RCO_OFS_CONTROL, 32'h93);
        cyc(40);
        wait_high();
        sleep <= 1'b1;
        cyc(2);
        #1;
        lvl = pin;
        r0 = rises;
        cyc(30);
        #1;
        chk(32'(pin), 32'(lvl));
        chk(32'(rises - r0), 32'h0);
        @(posedge i_clock);
        sleep <= 1'b0;
        apb(1'b1, RCO_OFS_CONTROL, 32'h13);
        $display("test sleep done");
    endtask : t_sleep
    task automatic t_src();
        logic [3:0] codes [11];
        logic [15:0] r0;
        codes = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'h5, 4'hb};
        foreach (codes[k])
        begin
            mask <= k < 9 ? 9'(1 << k) : 9'h1ff;
            apb(1'b1, RCO_OFS_SOURCE, 32'(codes[k]));
            apb(1'b1, RCO_OFS_CONTROL, 32'h90);
            r0 = rises;
            cyc(80);
            chk(32'(rises - r0 != 16'h0), 32'(k < 9));
            apb(1'b1, RCO_OFS_CONTROL, 32'h10);
        end
        apb(1'b1, RCO_OFS_SOURCE, 32'h0);
        $display("test source done");
    endtask : t_src
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results
    initial
    begin
        repeat (5) @(posedge i_clock);
        i_arst_n <= 1'b1;
        t_regs();
        t_shape();
        t_stop();
        t_sleep();
        t_src();
        results();
    end
    // generous limit
    initial
    begin
        #2000000;
        err_total++;
        results();
    end
endmodule : rco_refclk_tb_top
`default_nettype wire

// *** rco_refclk_top.sv ***
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module rco_refclk_top
    import rco_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_arst_n,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [RCO_ADDR_W-1:0] i_paddr,
    input wire logic [RCO_DATA_W-1:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [RCO_DATA_W-1:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // clock sources from other domains
    input wire logic i_high_freq_internal_osc,
    input wire logic i_low_freq_internal_osc,
    input wire logic i_mid_freq_internal_osc_500k,
    input wire logic i_mid_freq_internal_osc_31k,
    input wire logic i_num_ctrl_osc_output,
    input wire logic i_logic_cell1_output,
    input wire logic i_logic_cell2_output,
    input wire logic i_logic_cell3_output,
    input wire logic i_logic_cell4_output,
    // device sleep, same clock domain
    input wire logic i_sleep,
    output logic o_refclk_out_pin
);

    // ------------------------------------------------------------------
    // source synchroniser
    // ------------------------------------------------------------------
    logic [RCO_NUM_ASYNC-1:0] src_raw;
    logic [RCO_NUM_ASYNC-1:0] sync1_q;
    logic [RCO_NUM_ASYNC-1:0] sync2_q;

    assign src_raw = {i_logic_cell4_output, i_logic_cell3_output, i_logic_cell2_output,
                      i_logic_cell1_output, i_num_ctrl_osc_output,
                      i_mid_freq_internal_osc_31k, i_mid_freq_internal_osc_500k,
                      i_low_freq_internal_osc, i_high_freq_internal_osc};

    // sources faster than half of the clock will alias; no filter here
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
        end
        else
        begin
            sync1_q <= src_raw;
            sync2_q <= sync1_q;
        end
    end

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    logic setup;
    logic access;
    logic hit_control;
    logic hit_source;
    logic hit_status;
    logic hit_any;
    logic wr_lane0;
    logic wr_control;
    logic wr_source;

    assign setup = i_psel & ~i_penable;
    assign access = i_psel & i_penable;
    assign hit_control = (i_paddr == RCO_OFS_CONTROL);
    assign hit_source = (i_paddr == RCO_OFS_SOURCE);
    assign hit_status = (i_paddr == RCO_OFS_STATUS);
    assign hit_any = hit_control | hit_source | hit_status;
    assign wr_lane0 = access & i_pwrite & i_pstrb[0];
    assign wr_control = wr_lane0 & hit_control;
    assign wr_source = wr_lane0 & hit_source;

    // zero wait states: every access completes in its first access cycle
    assign o_pready = 1'b1;
    assign o_pslverr = access & ~hit_any;

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    logic [7:0] control_q, control_d;
    logic [7:0] source_q, source_d;
    logic enable;
    logic [RCO_DIV_W-1:0] div_sel;
    logic [RCO_DUTY_W-1:0] duty_sel;
    logic [RCO_SRC_W-1:0] src_sel;

    // divider and duty stay writable while running; the glitch is accepted
    always_comb
    begin
        control_d = control_q;
        source_d = source_q;
        if (wr_control)
        begin
            control_d = i_pwdata[7:0] & RCO_CTRL_MASK;
        end
        if (wr_source)
        begin
            source_d = i_pwdata[7:0] & RCO_SRC_MASK;
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            control_q <= RCO_CTRL_RESET;
            source_q <= RCO_SRC_RESET;
        end
        else
        begin
            control_q <= control_d;
            source_q <= source_d;
        end
    end

    assign enable = control_q[RCO_EN_POS];
    assign div_sel = control_q[RCO_DIV_LSB +: RCO_DIV_W];
    assign duty_sel = control_q[RCO_DUTY_LSB +: RCO_DUTY_W];
    assign src_sel = source_q[RCO_SRC_W-1:0];

    // ------------------------------------------------------------------
    // generator datapath
    // ------------------------------------------------------------------
    rco_gen_if gi();

    assign gi.src_sel = src_sel;
    assign gi.div_sel = div_sel;
    assign gi.duty_sel = duty_sel;
    assign gi.hold = i_sleep;

    rco_src_pick u_pick (
        .i_clock(i_clock),
        .i_arst_n(i_arst_n),
        .i_sync(sync2_q),
        .g(gi.pick)
    );

    rco_wave_gen u_wave (
        .i_clock(i_clock),
        .i_arst_n(i_arst_n),
        .g(gi.gen)
    );

    // ------------------------------------------------------------------
    // enable sequencing
    // ------------------------------------------------------------------
    rco_state_t state_q, state_d;
    logic [RCO_SRC_W-1:0] run_src_q, run_src_d;
    logic start;
    logic src_changed;

    assign src_changed = (run_src_q != src_sel);

    always_comb
    begin
        state_d = state_q;
        run_src_d = run_src_q;
        start = 1'b0;
        unique case (state_q)
            RCO_OFF:
            begin
                if (enable && gi.src_valid)
                begin
                    state_d = RCO_ARM;
                    run_src_d = src_sel;
                end
            end
            RCO_ARM:
            begin
                if (!enable || !gi.src_valid)
                begin
                    state_d = RCO_OFF;
                end
                else if (src_changed)
                begin
                    run_src_d = src_sel;
                end
                else if (gi.src_rise && !i_sleep)
                begin
                    // phase zero is aligned to a real source edge
                    state_d = RCO_RUN;
                    start = 1'b1;
                end
            end
            RCO_RUN:
            begin
                if (!enable || !gi.src_valid)
                begin
                    state_d = RCO_OFF;
                end
                else if (src_changed)
                begin
                    // re-arm so a new source also starts on a clean edge
                    state_d = RCO_ARM;
                    run_src_d = src_sel;
                end
            end
            default:
            begin
                state_d = RCO_OFF;
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            state_q <= RCO_OFF;
            run_src_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            run_src_q <= run_src_d;
        end
    end

    assign gi.start = start;

    // ------------------------------------------------------------------
    // output pin
    // ------------------------------------------------------------------
    logic out_q, out_d;

    always_comb
    begin
        out_d = 1'b0;
        if (state_q == RCO_RUN && enable && gi.src_valid && !src_changed)
        begin
            if (i_sleep)
            begin
                out_d = out_q;
            end
            else if (div_sel == RCO_DIV_NONE)
            begin
                out_d = gi.src_level;
            end
            else
            begin
                out_d = gi.wave_next;
            end
        end
        else if (state_q == RCO_ARM && start)
        begin
            if (div_sel == RCO_DIV_NONE)
            begin
                out_d = gi.src_level;
            end
            else
            begin
                out_d = gi.wave_next;
            end
        end
        else if (state_q == RCO_RUN && i_sleep && enable)
        begin
            out_d = out_q;
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            out_q <= 1'b0;
        end
        else
        begin
            out_q <= out_d;
        end
    end

    assign o_refclk_out_pin = out_q;

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    logic [RCO_DATA_W-1:0] prdata_q, prdata_d;
    logic [7:0] status;

    always_comb
    begin
        status = 8'h00;
        status[RCO_STAT_RUN_POS] = (state_q == RCO_RUN);
        status[RCO_STAT_ARM_POS] = (state_q == RCO_ARM);
        status[RCO_STAT_OUT_POS] = out_q;
    end

    // captured in the setup cycle, so read data comes straight from a flop
    always_comb
    begin
        prdata_d = prdata_q;
        if (setup && !i_pwrite)
        begin
            prdata_d = '0;
            if (hit_control)
            begin
                prdata_d[7:0] = control_q & RCO_CTRL_MASK;
            end
            else if (hit_source)
            begin
                prdata_d[7:0] = source_q & RCO_SRC_MASK;
            end
            else if (hit_status)
            begin
                prdata_d[7:0] = status;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            prdata_q <= '0;
        end
        else
        begin
            prdata_q <= prdata_d;
        end
    end

    assign o_prdata = prdata_q;

endmodule : rco_refclk_top
`default_nettype wire

// *** rco_src_pick.sv ***
`timescale 1ns/1ps
`default_nettype none
module rco_src_pick
    import rco_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_arst_n,
    input wire logic [RCO_NUM_ASYNC-1:0] i_sync,
    rco_gen_if.pick g
);
    logic fosc_q, fosc_d;
    logic level_q, level_d;
    logic prev_q;
    logic valid;

    // ------------------------------------------------------------------
    // source mux
    // ------------------------------------------------------------------
    // system clock is seen as a toggle: one half period per rising clock edge
    always_comb
    begin
        fosc_d = ~fosc_q;
        valid = 1'b1;
        unique case (g.src_sel)
            RCO_SRC_FOSC: level_d = fosc_q;
            RCO_SRC_HFOSC: level_d = i_sync[0];
            RCO_SRC_LFOSC: level_d = i_sync[1];
            RCO_SRC_MF500K: level_d = i_sync[2];
            RCO_SRC_MF31K: level_d = i_sync[3];
            RCO_SRC_NCO: level_d = i_sync[4];
            RCO_SRC_LC1: level_d = i_sync[5];
            RCO_SRC_LC2: level_d = i_sync[6];
            RCO_SRC_LC3: level_d = i_sync[7];
            RCO_SRC_LC4: level_d = i_sync[8];
            default:
            begin
                level_d = 1'b0;
                valid = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            fosc_q <= 1'b0;
            level_q <= 1'b0;
            prev_q <= 1'b0;
        end
        else
        begin
            fosc_q <= fosc_d;
            level_q <= level_d;
            prev_q <= level_q;
        end
    end

    assign g.src_level = level_q;
    assign g.src_edge = level_q ^ prev_q;
    assign g.src_rise = level_q & ~prev_q;
    assign g.src_valid = valid;
endmodule : rco_src_pick
`default_nettype wire

// *** rco_wave_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
module rco_wave_gen
    import rco_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_arst_n,
    rco_gen_if.gen g
);
    logic [RCO_PHASE_W-1:0] phase_q, phase_d;
    logic [RCO_PHASE_W-1:0] last;

    // ------------------------------------------------------------------
    // half-period phase counter
    // ------------------------------------------------------------------
    always_comb
    begin
        last = rco_period_last(g.div_sel);
        phase_d = phase_q;
        if (g.start)
        begin
            phase_d = '0;
        end
        else if (g.hold)
        begin
            phase_d = phase_q;
        end
        else if (g.src_edge)
        begin
            // >= lets a shrunk divider recover instead of running to wrap
            if (phase_q >= last)
            begin
                phase_d = '0;
            end
            else
            begin
                phase_d = phase_q + 8'h01;
            end
        end
        g.wave_next = {1'b0, phase_d} < rco_high_len(g.div_sel, g.duty_sel);
    end

    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            phase_q <= '0;
        end
        else
        begin
            phase_q <= phase_d;
        end
    end
endmodule : rco_wave_gen
`default_nettype wire
